// [include/clm_defs.vh]
`ifndef CLM_DEFS_VH
`define CLM_DEFS_VH
// Register byte offsets
`define CLM_OFF_CTRL 8'h00
`define CLM_OFF_DIV 8'h04
`define CLM_OFF_STAT 8'h08
`define CLM_OFF_ISTAT 8'h0C
`define CLM_OFF_IMASK 8'h10
`define CLM_OFF_WORD 8'h14
// Control register fields
`define CLM_CTRL_AUTO 0
`define CLM_CTRL_FDATA 1
`define CLM_CTRL_FREF 2
`define CLM_CTRL_PCIE 3
`define CLM_CTRL_CDREN 4
`define CLM_CTRL_W 5
`define CLM_CTRL_RST 5'h11
// Divider register fields
`define CLM_DIV_N_LO 0
`define CLM_DIV_M_LO 8
`define CLM_DIV_LR_LO 16
`define CLM_DIV_LD_LO 24
`define CLM_PS_W 4
`define CLM_M_W 5
`define CLM_PS_RST 4'h1
`define CLM_M_RST 5'h04
// Status register fields
`define CLM_ST_LOCK 0
`define CLM_ST_FREQ 1
`define CLM_ST_PHASE 2
`define CLM_ST_SIGDET 3
`define CLM_ST_PMARST 4
// Interrupt event bits
`define CLM_EV_ENTER 0
`define CLM_EV_LEAVE 1
`define CLM_EV_BADDIV 2
`define CLM_EV_SLIP 3
`define CLM_EV_W 4
`define CLM_EV_RST 4'h0
// Synchronised pin indices
`define CLM_PIN_FREQ 0
`define CLM_PIN_PHASE 1
`define CLM_PIN_SIGDET 2
`define CLM_PIN_PMARST 3
`define CLM_PIN_SER 4
`define CLM_PIN_W 5
`endif

// [rtl/clm_cdr_lock_ctrl.v]
// Function
// R1 - Front-end reset always starts in reference tracking
// R2 - Auto: enter data on freq, phase, signal
// R3 - Auto: leave data on freq loss, signal loss
// R4 - Lock status output marks mode transitions
// R5 - Manual: mode from two force settings only
// R6 - Manual: user keeps clock near optimum rate
// R7 - Reference tracking: phase detector off, reference L
// R8 - Lock detect meaningless while tracking data
// R9 - User holds protocol logic until data lock
// R10 - Idle line: operator returns to reference
// R11 - Pre-scale, post-scale dividers accept 1,2,4,8
// R12 - Feedback counter accepts listed values only
// R13 - Deserializer: first bit is word LSB
// R14 - Aligner drives clock slip, words aligned
// R15 - Controller used only in recovery role
// R16 - Both forces set: reference tracking wins
// R17 - Lock status high exactly in data tracking
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "clm_defs.vh"
module clm_cdr_lock_ctrl #(
	parameter WORD_W = 10,
	parameter BIT_DIV = 2
) (
	// Clock and synchronous reset
	input wire clk,
	input wire reset_n,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Analogue front end, asynchronous
	input wire ppm_in_range,
	input wire phase_in_range,
	input wire sig_detect,
	input wire pma_reset,
	input wire rx_serial_in,
	// Word aligner, same clock
	input wire slip_req,
	// Loop control
	output reg rx_data_lock_status,
	output reg ref_tracking_mode,
	output reg freq_phase_detector_en,
	output reg phase_detector_en,
	output reg [3:0] cfg_n,
	output reg [4:0] cfg_m,
	output reg [3:0] cfg_l_active,
	// Parallel data
	output reg [WORD_W-1:0] rx_word,
	output reg rx_word_valid,
	output reg slip_done,
	// Interrupt
	output wire irq
);
	localparam ST_REF = 2'b01;
	localparam ST_DATA = 2'b10;
	localparam CW = 8;

	// Only powers of two up to eight
	function legal_ps;
		input [3:0] v;
		begin
			legal_ps = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
		end
	endfunction

	// Only the listed feedback multipliers
	function legal_m;
		input [4:0] v;
		begin
			case (v)
				5'h04, 5'h05, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h14, 5'h19: legal_m = 1'b1;
				default: legal_m = 1'b0;
			endcase
		end
	endfunction

	reg [`CLM_PIN_W-1:0] sync1_q;
	reg [`CLM_PIN_W-1:0] sync2_q;
	reg [`CLM_CTRL_W-1:0] ctrl_q;
	reg [`CLM_PS_W-1:0] n_q;
	reg [`CLM_M_W-1:0] m_q;
	reg [`CLM_PS_W-1:0] lr_q;
	reg [`CLM_PS_W-1:0] ld_q;
	reg [`CLM_EV_W-1:0] istat_q;
	reg [`CLM_EV_W-1:0] imask_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [CW-1:0] bdiv_q;
	reg bit_en_q;
	reg [WORD_W-1:0] shift_q;
	reg [CW-1:0] bcnt_q;
	reg slip_pend_q;
	reg [`CLM_EV_W-1:0] ev;
	reg [31:0] rd_d;
	reg dec_ok;

	wire freq_ok = sync2_q[`CLM_PIN_FREQ];
	wire phase_ok = sync2_q[`CLM_PIN_PHASE];
	wire sig_ok = sync2_q[`CLM_PIN_SIGDET];
	wire pma_rst = sync2_q[`CLM_PIN_PMARST];
	wire ser_bit = sync2_q[`CLM_PIN_SER];
	wire auto_m = ctrl_q[`CLM_CTRL_AUTO];
	wire pcie = ctrl_q[`CLM_CTRL_PCIE];
	wire cdr_en = ctrl_q[`CLM_CTRL_CDREN];
	wire f_data = ctrl_q[`CLM_CTRL_FDATA];
	wire f_ref = ctrl_q[`CLM_CTRL_FREF];
	wire wr = psel & penable & pwrite;
	wire [3:0] wn = pwdata[`CLM_DIV_N_LO +: `CLM_PS_W];
	wire [4:0] wm = pwdata[`CLM_DIV_M_LO +: `CLM_M_W];
	wire [3:0] wlr = pwdata[`CLM_DIV_LR_LO +: `CLM_PS_W];
	wire [3:0] wld = pwdata[`CLM_DIV_LD_LO +: `CLM_PS_W];
	wire div_wr = wr && (paddr == `CLM_OFF_DIV);
	wire div_good = legal_ps(wn) & legal_m(wm) & legal_ps(wlr) & legal_ps(wld);
	wire word_end = bit_en_q && !slip_pend_q && (bcnt_q == WORD_W - 1);

	// Two flops before any front-end pin is read; first stage feeds only the second
	always @(posedge clk) begin
		if (!reset_n) begin
			sync1_q <= {`CLM_PIN_W{1'b0}};
			sync2_q <= {`CLM_PIN_W{1'b0}};
		end else begin
			sync1_q <= {rx_serial_in, pma_reset, sig_detect, phase_in_range, ppm_in_range};
			sync2_q <= sync1_q;
		end
	end

	// Mode decision; manual forces win over anything the detectors say
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_REF: begin
				if (!auto_m) begin
					if (!f_ref && f_data)
						state_d = ST_DATA; // [R5] [R16]
				end else if (freq_ok && phase_ok && (!pcie || sig_ok)) begin
					state_d = ST_DATA; // [R2]
				end
			end
			ST_DATA: begin
				if (!auto_m) begin
					if (f_ref || !f_data)
						state_d = ST_REF; // [R5] [R16]
				end else if (!freq_ok || (pcie && !sig_ok)) begin
					state_d = ST_REF; // [R3]
				end
			end
			default: state_d = ST_REF;
		endcase
		// Transmit multiplier role never tracks data
		if (pma_rst || !cdr_en)
			state_d = ST_REF; // [R1] [R15]
	end

	// Mode register and the loop controls derived from it
	always @(posedge clk) begin
		if (!reset_n) begin
			state_q <= ST_REF; // [R1]
			rx_data_lock_status <= 1'b0;
			ref_tracking_mode <= 1'b1;
			freq_phase_detector_en <= 1'b1;
			phase_detector_en <= 1'b0;
		end else begin
			state_q <= state_d;
			rx_data_lock_status <= (state_d == ST_DATA); // [R4] [R17]
			ref_tracking_mode <= (state_d == ST_REF);
			freq_phase_detector_en <= (state_d == ST_REF); // [R7]
			phase_detector_en <= (state_d == ST_DATA); // [R7]
		end
	end

	// Divider settings follow the register with one cycle of delay
	always @(posedge clk) begin
		if (!reset_n) begin
			cfg_n <= `CLM_PS_RST;
			cfg_m <= `CLM_M_RST;
			cfg_l_active <= `CLM_PS_RST;
		end else begin
			cfg_n <= n_q;
			cfg_m <= m_q;
			cfg_l_active <= (state_q == ST_DATA) ? ld_q : lr_q; // [R7]
		end
	end

	// Bit-rate enable; the serial line is sampled at this slower rate
	always @(posedge clk) begin
		if (!reset_n) begin
			bdiv_q <= {CW{1'b0}};
			bit_en_q <= 1'b0;
		end else if (bdiv_q == BIT_DIV - 1) begin
			bdiv_q <= {CW{1'b0}};
			bit_en_q <= 1'b1;
		end else begin
			bdiv_q <= bdiv_q + 1'b1;
			bit_en_q <= 1'b0;
		end
	end

	// Serial to parallel; a slip swallows one bit to move the boundary
	always @(posedge clk) begin
		if (!reset_n) begin
			shift_q <= {WORD_W{1'b0}};
			bcnt_q <= {CW{1'b0}};
			slip_pend_q <= 1'b0;
			rx_word <= {WORD_W{1'b0}};
			rx_word_valid <= 1'b0;
			slip_done <= 1'b0;
		end else begin
			rx_word_valid <= 1'b0;
			slip_done <= 1'b0;
			if (slip_req)
				slip_pend_q <= 1'b1; // [R14]
			if (bit_en_q) begin
				if (slip_pend_q) begin
					slip_pend_q <= 1'b0; // [R14]
					slip_done <= 1'b1;
				end else begin
					shift_q <= {ser_bit, shift_q[WORD_W-1:1]}; // [R13]
					if (word_end) begin
						bcnt_q <= {CW{1'b0}};
						rx_word <= {ser_bit, shift_q[WORD_W-1:1]}; // [R13]
						rx_word_valid <= 1'b1;
					end else begin
						bcnt_q <= bcnt_q + 1'b1;
					end
				end
			end
		end
	end

	// Events that may raise the interrupt
	always @* begin
		ev = {`CLM_EV_W{1'b0}};
		ev[`CLM_EV_ENTER] = (state_q == ST_REF) && (state_d == ST_DATA);
		ev[`CLM_EV_LEAVE] = (state_q == ST_DATA) && (state_d == ST_REF);
		ev[`CLM_EV_BADDIV] = div_wr && !div_good;
		ev[`CLM_EV_SLIP] = slip_done;
	end

	// Writable registers; an illegal divider write is dropped whole
	always @(posedge clk) begin
		if (!reset_n) begin
			ctrl_q <= `CLM_CTRL_RST;
			n_q <= `CLM_PS_RST;
			m_q <= `CLM_M_RST;
			lr_q <= `CLM_PS_RST;
			ld_q <= `CLM_PS_RST;
			imask_q <= `CLM_EV_RST;
			istat_q <= `CLM_EV_RST;
		end else begin
			if (wr && (paddr == `CLM_OFF_CTRL))
				ctrl_q <= pwdata[`CLM_CTRL_W-1:0];
			if (div_wr && div_good) begin
				n_q <= wn; // [R11]
				m_q <= wm; // [R12]
				lr_q <= wlr; // [R11]
				ld_q <= wld; // [R11]
			end
			if (wr && (paddr == `CLM_OFF_IMASK))
				imask_q <= pwdata[`CLM_EV_W-1:0];
			// Set beats a same-cycle write-one clear
			if (wr && (paddr == `CLM_OFF_ISTAT))
				istat_q <= (istat_q & ~pwdata[`CLM_EV_W-1:0]) | ev;
			else
				istat_q <= istat_q | ev;
		end
	end

	// Read mux and address decode
	always @* begin
		rd_d = 32'h0000_0000;
		dec_ok = 1'b1;
		case (paddr)
			`CLM_OFF_CTRL: rd_d[`CLM_CTRL_W-1:0] = ctrl_q;
			`CLM_OFF_DIV: begin
				rd_d[`CLM_DIV_N_LO +: `CLM_PS_W] = n_q;
				rd_d[`CLM_DIV_M_LO +: `CLM_M_W] = m_q;
				rd_d[`CLM_DIV_LR_LO +: `CLM_PS_W] = lr_q;
				rd_d[`CLM_DIV_LD_LO +: `CLM_PS_W] = ld_q;
			end
			`CLM_OFF_STAT: begin
				rd_d[`CLM_ST_LOCK] = (state_q == ST_DATA);
				rd_d[`CLM_ST_FREQ] = freq_ok;
				rd_d[`CLM_ST_PHASE] = phase_ok;
				rd_d[`CLM_ST_SIGDET] = sig_ok;
				rd_d[`CLM_ST_PMARST] = pma_rst;
			end
			`CLM_OFF_ISTAT: rd_d[`CLM_EV_W-1:0] = istat_q;
			`CLM_OFF_IMASK: rd_d[`CLM_EV_W-1:0] = imask_q;
			`CLM_OFF_WORD: rd_d[WORD_W-1:0] = rx_word;
			default: dec_ok = 1'b0;
		endcase
	end

	// Read data captured in the setup cycle so it stands for the access
	always @(posedge clk) begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= rd_d;
	end

	// No wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~dec_ok;
	assign irq = |(istat_q & imask_q);
endmodule

// [test/clm_far_end.sv]
`timescale 1ns/1ps
module clm_far_end #(
	parameter BIT_DIV = 2,
	parameter [9:0] WORD = 10'h00B
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Wanted front-end state: signal, phase, frequency
	input wire [2:0] cond,
	// Front-end status and serial line
	output wire ppm_in_range,
	output wire phase_in_range,
	output wire sig_detect,
	output wire rx_serial_in
);
	logic [2:0] st_q = 3'h0;
	int tick;
	int idx;
	// Detector levels lag the request by a cycle, as a slow analogue sensor would
	always @(posedge clk) begin
		st_q <= cond;
		if (!reset_n) begin
			tick <= 0;
			idx <= 0;
		end else if (tick == BIT_DIV - 1) begin
			tick <= 0;
			idx <= (idx + 1) % 10;
		end else begin
			tick <= tick + 1;
		end
	end
	// No lock-detect pin: it is meaningless while data is tracked
	// One word sent low bit first, repeated with no idle gap
	assign {sig_detect, phase_in_range, ppm_in_range} = st_q;
	assign rx_serial_in = WORD[idx];
endmodule

// [test/clm_lock_checker.sv]
`timescale 1ns/1ps
`include "clm_defs.vh"
module clm_lock_checker (
	// Clock, reset and bus
	input wire clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	// Front end and aligner
	input wire ppm_in_range,
	input wire phase_in_range,
	input wire sig_detect,
	input wire pma_reset,
	input wire slip_req,
	// Loop outputs
	input wire rx_data_lock_status,
	input wire ref_tracking_mode,
	input wire freq_phase_detector_en,
	input wire phase_detector_en,
	input wire [3:0] cfg_n,
	input wire [4:0] cfg_m,
	input wire [3:0] cfg_l_active,
	input wire slip_done
);
	reg [4:0] ctrl_q;
	wire aut;
	wire man;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Shadow of the control word; the mode bits reach a port only through prdata reads
	always @(posedge clk) begin
		if (!reset_n)
			ctrl_q <= `CLM_CTRL_RST;
		else if (psel && penable && pwrite && paddr == `CLM_OFF_CTRL)
			ctrl_q <= pwdata[4:0];
	end
	assign aut = ctrl_q[4] && ctrl_q[0];
	assign man = ctrl_q[4] && !ctrl_q[0];
	// Pins pass two synchroniser stages, hence the depth of three
	a_reset_ref: assert property ($rose(reset_n) |-> ref_tracking_mode) else $error("no ref");
	a_pma_ref: assert property (pma_reset |-> ##[1:4] ref_tracking_mode) else $error("pma");
	a_auto_enter: assert property (aut && $rose(rx_data_lock_status) |->
		$past(ppm_in_range, 3) && $past(phase_in_range, 3) && (!ctrl_q[3] || $past(sig_detect, 3)))
		else $error("early data lock");
	a_freq_leave: assert property (aut && rx_data_lock_status && !ppm_in_range
		|-> ##[1:4] ref_tracking_mode) else $error("freq loss kept");
	a_sig_leave: assert property (aut && ctrl_q[3] && rx_data_lock_status && !sig_detect
		|-> ##[1:4] ref_tracking_mode) else $error("sig loss kept");
	a_manual_data: assert property ((man && ctrl_q[1] && !ctrl_q[2] && !pma_reset)[*4]
		|-> rx_data_lock_status) else $error("force data ignored");
	a_force_ref: assert property ((man && ctrl_q[2])[*3] |-> ref_tracking_mode) else $error("fref");
	a_mode_flags: assert property (rx_data_lock_status == !ref_tracking_mode
		&& phase_detector_en == rx_data_lock_status && freq_phase_detector_en == ref_tracking_mode)
		else $error("mode flags clash");
	a_div_legal: assert property (cfg_n inside {1, 2, 4, 8} && cfg_l_active inside {1, 2, 4, 8})
		else $error("bad divider");
	a_mult_legal: assert property (cfg_m inside {4, 5, 8, 10, 12, 16, 20, 25})
		else $error("bad multiplier");
	a_slip_done: assert property (slip_req |-> ##[1:4] slip_done) else $error("slip lost");
	c_enter: cover property ($rose(rx_data_lock_status));
	c_leave: cover property ($fell(rx_data_lock_status));
	c_slip: cover property (slip_done);
	c_manual: cover property (man && $rose(rx_data_lock_status));
endmodule
bind clm_cdr_lock_ctrl clm_lock_checker u_chk (.*);

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "clm_defs.vh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, slip_req = 0, pma_reset = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, dexp = 32'h01010401;
	logic [2:0] cond = 0;
	logic err;
	wire [31:0] prdata;
	wire [9:0] rx_word;
	wire [3:0] cfg_n, cfg_l_active;
	wire [4:0] cfg_m;
	wire pready, pslverr, ppm_in_range, phase_in_range, sig_detect, rx_serial_in, irq;
	wire rx_data_lock_status, ref_tracking_mode, freq_phase_detector_en, phase_detector_en;
	wire rx_word_valid, slip_done;
	int fail_count = 0, samples_checked = 0, cyc = 0, i;
	clm_cdr_lock_ctrl #(.WORD_W(10), .BIT_DIV(2)) uut (.*);
	clm_far_end #(.BIT_DIV(2), .WORD(10'h00B)) u_far (.*);
	initial forever #20 clk = ~clk;
	task tally_and_finish;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Cut a hang short; the whole sequence needs only about six hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish;
		end
	end
	// One APB transfer, request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		`CHK(rd, e)
	endtask
	// Mode moves three edges after the pins; eight leaves margin
	task automatic wlk(input logic e);
		repeat (8) @(posedge clk);
		`CHK(rx_data_lock_status, e)
	endtask
	task automatic dtry(input logic [31:0] w, input logic ok);
		apb(1, `CLM_OFF_DIV, w);
		if (ok) dexp = w;
		rchk(`CLM_OFF_DIV, dexp);
	endtask
	task automatic wval;
		@(posedge clk);
		while (rx_word_valid !== 1'b1) @(posedge clk);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1;
		`CHK(ref_tracking_mode, 1'b1)
		rchk(`CLM_OFF_CTRL, 32'h11);
		rchk(`CLM_OFF_IMASK, 32'h0);
		apb(0, 8'h40, 0);
		`CHK(err, 1'b1)
		for (i = 0; i < 32; i++) begin
			if (i < 16) dtry(32'h01010400 | i, i inside {1, 2, 4, 8});
			if (i < 16) dtry(32'h00000401 | i << 16 | i << 24, i inside {1, 2, 4, 8});
			dtry(32'h01010001 | i << 8, i inside {4, 5, 8, 10, 12, 16, 20, 25});
		end
		rchk(`CLM_OFF_ISTAT, 32'h4);
		dtry(32'h04020801, 1);
		`CHK({cfg_n, cfg_m, cfg_l_active}, {4'h1, 5'h08, 4'h2})
		apb(1, `CLM_OFF_ISTAT, 32'hF);
		apb(1, `CLM_OFF_IMASK, 32'h3);
		cond <= 3'b001;
		wlk(0);
		cond <= 3'b011;
		wlk(1);
		`CHK({irq, cfg_l_active}, {1'b1, 4'h4})
		rchk(`CLM_OFF_STAT, 32'h7);
		rchk(`CLM_OFF_ISTAT, 32'h1);
		cond <= 3'b010;
		wlk(0);
		rchk(`CLM_OFF_ISTAT, 32'h3);
		apb(1, `CLM_OFF_ISTAT, 32'h3);
		apb(1, `CLM_OFF_IMASK, 32'h0);
		apb(1, `CLM_OFF_CTRL, 32'h19);
		cond <= 3'b011;
		wlk(0);
		cond <= 3'b111;
		wlk(1);
		`CHK(irq, 1'b0)
		pma_reset <= 1;
		wlk(0);
		pma_reset <= 0;
		wlk(1);
		cond <= 3'b011;
		wlk(0);
		cond <= 3'b000;
		// Manual settings alone pick the mode, with the detectors all out of range
		for (i = 0; i < 4; i++) begin
			apb(1, `CLM_OFF_CTRL, 32'h10 | i << 1);
			wlk(i == 1);
		end
		apb(1, `CLM_OFF_CTRL, 32'h11);
		wval;
		for (i = 0; i < 12 && rx_word !== 10'h00B; i++) begin
			slip_req <= 1;
			@(posedge clk);
			slip_req <= 0;
			wval;
			wval;
		end
		`CHK(rx_word, 10'h00B)
		slip_req <= 1;
		@(posedge clk);
		slip_req <= 0;
		wval;
		wval;
		`CHK(rx_word, 10'h205)
		rchk(`CLM_OFF_WORD, 32'h205);
		tally_and_finish;
	end
endmodule
